// *** design/ctpd_pulse_delay_gen.v ***
// pulse delay generator control logic of the charge-time unit
// Operation
// - enable bit enters pulse mode, drives pulse_out
// - select bit picks comparator or trigger pin
// - comparator trip ends pulse when select clear
// - trigger pin high ends pulse when select set
`timescale 1ns/100ps
`include "ctpd_consts.vh"
module ctpd_pulse_delay_gen (
   input wire clk,
   input wire sys_rst,
   input wire delay_gen_enable,
   input wire delay_source_select,
   input wire edge_one_status,
   input wire comparator_out,
   input wire delay_trigger_in,
   output reg pulse_out,
   output reg pulse_done
);
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [2:0] cmp_sync_q;
   reg [2:0] trg_sync_q;
   reg cmp_lvl_q;
   reg trg_lvl_q;
   reg start_prev_q;
   reg pulse_d;
   reg done_d;
   wire trip;
   wire start;

   // three-stage synchronisers; level changes only when stages 2 and 3 agree
   always @(posedge clk) begin
      if (sys_rst) begin
         cmp_sync_q <= `CTPD_SYNC_RST;
         trg_sync_q <= `CTPD_SYNC_RST;
         cmp_lvl_q <= 1'b0;
         trg_lvl_q <= 1'b0;
      end else begin
         cmp_sync_q <= {cmp_sync_q[1:0], comparator_out};
         trg_sync_q <= {trg_sync_q[1:0], delay_trigger_in};
         if (cmp_sync_q[1] == cmp_sync_q[2]) begin
            cmp_lvl_q <= cmp_sync_q[2];
         end
         if (trg_sync_q[1] == trg_sync_q[2]) begin
            trg_lvl_q <= trg_sync_q[2];
         end
      end
   end

   // source mux: comparator when clear, trigger pin when set
   assign trip = (delay_source_select == `CTPD_SRC_TRIGGER) ? trg_lvl_q :
                 cmp_lvl_q;
   // start on rising edge of the edge-one status, so a held bit fires once
   assign start = edge_one_status & ~start_prev_q;

   always @(posedge clk) begin
      if (sys_rst) begin
         start_prev_q <= 1'b0;
      end else begin
         start_prev_q <= edge_one_status;
      end
   end

   // pulse state machine
   always @* begin
      state_d = state_q;
      pulse_d = `CTPD_PULSE_RST;
      done_d = 1'b0;
      case (state_q)
         `CTPD_ST_IDLE: begin
            // an already tripped source would give a zero width pulse
            if (delay_gen_enable && start && !trip) begin
               state_d = `CTPD_ST_PULSE;
               pulse_d = 1'b1;
            end
         end
         `CTPD_ST_PULSE: begin
            if (!delay_gen_enable) begin
               state_d = `CTPD_ST_IDLE;
            end else if (trip) begin
               state_d = `CTPD_ST_DONE;
               done_d = 1'b1;
            end else begin
               pulse_d = 1'b1;
            end
         end
         `CTPD_ST_DONE: begin
            // wait for software to drop the start bit before rearming
            if (!edge_one_status || !delay_gen_enable) begin
               state_d = `CTPD_ST_IDLE;
            end
         end
         default: begin
            state_d = `CTPD_ST_IDLE;
         end
      endcase
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         state_q <= `CTPD_ST_IDLE;
         pulse_out <= `CTPD_PULSE_RST;
         pulse_done <= 1'b0;
      end else begin
         state_q <= state_d;
         pulse_out <= pulse_d;
         pulse_done <= done_d;
      end
   end
endmodule // ctpd_pulse_delay_gen

// *** design/ctpd_consts.vh ***
// constants for the charge-time pulse delay generator
`ifndef CTPD_CONSTS_VH
`define CTPD_CONSTS_VH
// source select encodings
`define CTPD_SRC_COMPARATOR 1'b0
`define CTPD_SRC_TRIGGER 1'b1
// state codes
`define CTPD_ST_IDLE 2'h0
`define CTPD_ST_PULSE 2'h1
`define CTPD_ST_DONE 2'h2
// reset values
`define CTPD_PULSE_RST 1'b0
`define CTPD_SYNC_RST 3'h0
`endif

// *** bench/ctpd_chk.sv ***
// port checks
`timescale 1ns/100ps
module ctpd_chk (input wire clk, sys_rst, delay_gen_enable, pulse_out,
   pulse_done, edge_one_status);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_off_idle: assert property (!delay_gen_enable |=> !pulse_out)
      else $error("on");
   a_done_fall: assert property (pulse_done |-> $fell(pulse_out))
      else $error("done");
   a_done_single: assert property (pulse_done |=> !pulse_done)
      else $error("done held");
   a_rise_start: assert property ($rose(pulse_out) |->
      $past(delay_gen_enable) && $past(edge_one_status))
      else $error("rise");
   a_pulse_hold: assert property (pulse_out && delay_gen_enable |=>
      pulse_out || pulse_done)
      else $error("hold");
endmodule // ctpd_chk

// *** bench/ctpd_src.sv ***
// source model
`timescale 1ns/100ps
module ctpd_src (input wire clk, edge_one_status, input wire [31:0] dly,
   output reg comparator_out = 0, delay_trigger_in = 0);
   int n = 0;
   // pin trips 8 cycles after the comparator
   always @(posedge clk) begin
      n <= edge_one_status ? n + 1 : 0;
      comparator_out <= n >= dly;
      delay_trigger_in <= n >= dly + 8;
   end
endmodule // ctpd_src

// *** bench/test_ctpd_pulse_delay_gen.sv ***
// bench
`timescale 1ns/100ps
module test_ctpd_pulse_delay_gen;
   reg clk = 0, sys_rst = 1, delay_gen_enable = 0, edge_one_status = 0,
      delay_source_select = 0;
   wire comparator_out, delay_trigger_in, pulse_out, pulse_done;
   int fails = 0, checked = 0, seed = 35328, k, i, w, dly = 3;
   ctpd_pulse_delay_gen i_dut (.clk(clk), .sys_rst(sys_rst),
      .delay_gen_enable(delay_gen_enable),
      .delay_source_select(delay_source_select),
      .edge_one_status(edge_one_status), .comparator_out(comparator_out),
      .delay_trigger_in(delay_trigger_in), .pulse_out(pulse_out),
      .pulse_done(pulse_done));
   ctpd_src i_src (.clk(clk), .edge_one_status(edge_one_status),
      .dly(dly), .comparator_out(comparator_out),
      .delay_trigger_in(delay_trigger_in));
   always #4 clk = ~clk;
   task check(input [15:0] s, e);
      if (s !== e) $display("mismatch %0t %h %h", $time, s, e);
      fails = fails + (s !== e);
      checked = checked + 1;
   endtask
   task finish_test;
      $display("fails %0d checked %0d", fails, checked);
      if (fails == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      sys_rst <= 0;
      for (k = 0; k < 5; k = k + 1) begin
         repeat (8) @(posedge clk) dly <= 3 + {$random(seed)} % 16;
         delay_source_select <= k[0];
         @(posedge clk) delay_gen_enable <= k < 4;
         @(posedge clk) edge_one_status <= 1;
         for (i = 0, w = 0; i < 90 && pulse_done !== 1; i = i + 1)
            @(posedge clk) #1 w = w + pulse_out;
         check(i < 90, k < 4);
         check(w, k > 3 ? 0 : dly + 5 + 8 * k[0]);
         @(posedge clk) edge_one_status <= 0;
      end
      finish_test;
   end
endmodule // test_ctpd_pulse_delay_gen
bind ctpd_pulse_delay_gen ctpd_chk i_chk (.clk(clk), .sys_rst(sys_rst),
   .delay_gen_enable(delay_gen_enable), .pulse_out(pulse_out),
   .pulse_done(pulse_done), .edge_one_status(edge_one_status));
